/* File: sdei_top.sv */
// Drop-event interrupt logic of the switch buffer manager: mask and double-buffered status.
// Assumes an APB master on clk_sys and drop events from buffer manager logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdei_defs.svh"

// Contract
// R1 - Mask bit one blocks interrupt, resets one
// R2 - Status recording ignores the mask
// R3 - Two independent slots A and B
// R4 - Slot B reason in bits 13:10
// R5 - Reason codes 0000 to 0011
// R6 - Reason codes 0100 to 0110, 1001
// R7 - Slot B port in bits 9:8
// R8 - Slot A reason in bits 6:3
// R9 - Slot A port in bits 2:1
// R10 - Slot A valid bit 0, clear on read
// R11 - Interrupt while any valid and unmasked
// R12 - Fill A, then B, else discard
module sdei_top (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic drop_valid,
	input wire sdei_pkg::sdei_reason_t drop_reason,
	input wire sdei_pkg::sdei_port_t drop_port,
	output logic irq
);
	import sdei_pkg::*;

	// Word index of a byte address, or all ones when misaligned
	function automatic logic [29:0] word_idx(input logic [31:0] a);
		word_idx = (a[1:0] == 2'h0) ? a[31:2] : 30'h3fff_ffff;
	endfunction

	// Packs both slots into the pending register layout
	function automatic logic [31:0] pack_pend(input sdei_slot_s a, input sdei_slot_s b);
		logic [31:0] w;
		// Reserved bits stay zero
		w = `SDEI_PEND_RST;
		// R10 slot A valid
		w[`SDEI_A_VALID] = a.valid;
		// R9 slot A port
		w[`SDEI_A_PORT_HI:`SDEI_A_PORT_LO] = a.port;
		// R8 slot A reason
		w[`SDEI_A_RSN_HI:`SDEI_A_RSN_LO] = a.reason;
		// R3 slot B valid
		w[`SDEI_B_VALID] = b.valid;
		// R7 slot B port
		w[`SDEI_B_PORT_HI:`SDEI_B_PORT_LO] = b.port;
		// R4 slot B reason
		w[`SDEI_B_RSN_HI:`SDEI_B_RSN_LO] = b.reason;
		pack_pend = w;
	endfunction

	// Register state
	logic mask_q, mask_d; // Global interrupt mask
	sdei_slot_s slot_a_q, slot_a_d; // First status slot
	sdei_slot_s slot_b_q, slot_b_d; // Second status slot
	sdei_apb_e apb_q, apb_d; // Bus phase
	logic [31:0] prdata_q, prdata_d; // Read data
	logic pready_q, pready_d; // Access completion
	logic pslverr_q, pslverr_d; // Error answer
	logic irq_q, irq_d; // Interrupt output

	// Decoded access, valid in the cycle before completion
	logic acc_go;
	logic hit_mask;
	logic hit_pend;
	logic rd_pend;
	logic wr_mask; // Mask write with its byte lane on
	logic [29:0] idx;

	// Address decode
	always_comb begin
		// Misaligned addresses never match a register
		idx = word_idx(paddr);
		hit_mask = (idx == 30'(`SDEI_IDX_MASK));
		hit_pend = (idx == 30'(`SDEI_IDX_PEND));
		// Access cycle still waiting for its answer
		acc_go = psel && penable && (apb_q == SDEI_ACC) && !pready_q;
		// Clearing read of the pending register
		rd_pend = acc_go && !pwrite && hit_pend;
		// Mask write with the low byte lane on
		wr_mask = acc_go && pwrite && hit_mask && pstrb[0];
	end

	// APB slave: one wait state, answer on the second access cycle
	always_comb begin
		apb_d = apb_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		case (apb_q)
			SDEI_IDLE: begin
				// Setup seen
				if (psel && !penable) begin
					apb_d = SDEI_ACC;
				end
			end
			SDEI_ACC: begin
				if (pready_q) begin
					// Completed, wait for next setup
					apb_d = (psel && !penable) ? SDEI_ACC : SDEI_IDLE;
				end else if (acc_go) begin
					// Access cycle: answer on the next edge
					pready_d = 1'b1;
					// Unmapped or misaligned gets an error
					pslverr_d = !(hit_mask || hit_pend);
					if (!pwrite) begin
						// Reserved bits read zero
						if (hit_mask) begin
							prdata_d = {31'h0, mask_q};
						end else if (hit_pend) begin
							prdata_d = pack_pend(slot_a_q, slot_b_q);
						end else begin
							prdata_d = 32'h0;
						end
					end
				end else if (!psel) begin
					// Master gave up, back to idle
					apb_d = SDEI_IDLE;
				end
			end
			default: begin
				// Unused codes recover to idle
				apb_d = SDEI_IDLE;
			end
		endcase
	end

	// Mask register write
	always_comb begin
		mask_d = mask_q;
		// R1 mask write path
		if (wr_mask) begin
			mask_d = pwdata[`SDEI_MASK_BIT];
		end
	end

	// Slot capture and clear on read
	always_comb begin
		slot_a_d = slot_a_q;
		slot_b_d = slot_b_q;
		// R10 clear on read, both slots returned first
		if (rd_pend) begin
			slot_a_d = '0;
			slot_b_d = '0;
		end
		// R2 capture regardless of mask
		// R3 two slots, R12 fill A then B
		// Event in the read cycle lands in an emptied slot, so it is not lost
		// R5 R6 codes stored unchanged
		if (drop_valid) begin
			if (!slot_a_d.valid) begin
				slot_a_d = '{valid: 1'b1, reason: drop_reason, port: drop_port};
			end else if (!slot_b_d.valid) begin
				slot_b_d = '{valid: 1'b1, reason: drop_reason, port: drop_port};
			end
		end
	end

	// Interrupt level
	always_comb begin
		// R11 R1 gated by mask
		irq_d = (slot_a_d.valid || slot_b_d.valid) && !mask_d;
	end

	// State registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		// Reset values of every register
		if (!arst_n) begin
			mask_q <= `SDEI_MASK_RST;
			slot_a_q <= '0;
			slot_b_q <= '0;
			apb_q <= SDEI_IDLE;
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			// Load next values
			mask_q <= mask_d;
			slot_a_q <= slot_a_d;
			slot_b_q <= slot_b_d;
			apb_q <= apb_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// Checks run on the system clock and sleep while reset is low

	// Setup cycle of a fresh transfer
	sequence s_apb_setup;
		psel && !penable && !pready;
	endsequence

	// First access cycle after a setup
	sequence s_apb_access;
		psel && penable;
	endsequence

	// Clearing read that meets a new event
	sequence s_read_event;
		rd_pend && drop_valid;
	endsequence

	// Mask write with its byte lane enabled
	sequence s_mask_write;
		wr_mask;
	endsequence

	// Event captured when slot A was empty
	sequence s_a_empty_event;
		drop_valid && !slot_a_q.valid && !rd_pend;
	endsequence

	// R12 first event goes to slot A
	chk_fill_slot_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
		s_a_empty_event |=> slot_a_q.valid && slot_a_q.reason == $past(drop_reason)
			&& slot_a_q.port == $past(drop_port))
		else $error("slot A did not capture event");

	// R12 second event goes to slot B
	chk_fill_slot_b: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
		drop_valid && slot_a_q.valid && !slot_b_q.valid && !rd_pend
			|=> slot_b_q.valid && slot_b_q.reason == $past(drop_reason) && slot_a_q.valid)
		else $error("slot B did not capture event");

	// Full slots discard events
	chk_discard_full: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
		slot_a_q.valid && slot_b_q.valid && !rd_pend |=> $stable(slot_a_q) && $stable(slot_b_q))
		else $error("full slots changed");

	// Irq follows valid and mask
	chk_irq_level: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
		irq == ((slot_a_q.valid || slot_b_q.valid) && !mask_q))
		else $error("irq level wrong");

	// Mask blocks but recording still happens
	chk_mask_record: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
		(mask_q && !wr_mask) and s_a_empty_event |=> slot_a_q.valid && !irq)
		else $error("masked event not recorded");

	// Read clears pending within one cycle
	chk_read_clear: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
		rd_pend && !drop_valid |=> !slot_a_q.valid && !slot_b_q.valid)
		else $error("pending not cleared on read");

	// Read returns layout of both slots
	chk_read_layout: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
		rd_pend |=> prdata[13:10] == $past(slot_b_q.reason) && prdata[9:8] == $past(slot_b_q.port)
			&& prdata[7] == $past(slot_b_q.valid) && prdata[6:3] == $past(slot_a_q.reason)
			&& prdata[2:1] == $past(slot_a_q.port) && prdata[0] == $past(slot_a_q.valid))
		else $error("pending read layout wrong");

	// Access completes two cycles after setup
	chk_apb_ready: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		s_apb_setup ##1 s_apb_access |=> pready)
		else $error("apb access not completed");

	// Mask write lands on the decided edge
	chk_mask_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		s_mask_write |=> mask_q == $past(pwdata[`SDEI_MASK_BIT]))
		else $error("mask write lost");

	// Mask holds without a write
	chk_mask_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		!wr_mask |=> $stable(mask_q))
		else $error("mask changed without write");

	// Mask read returns the bit alone
	chk_mask_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		acc_go && !pwrite && hit_mask |=> prdata == {31'h0, $past(mask_q)})
		else $error("mask read wrong");

	// Set mask keeps the line low
	chk_irq_masked: assert property (@(posedge clk_sys) disable iff (!arst_n) // R1
		mask_q |-> !irq)
		else $error("irq high while masked");

	// Clear mask and a held slot raise the line
	chk_irq_unmasked: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
		!mask_q && (slot_a_q.valid || slot_b_q.valid) |-> irq)
		else $error("irq low while unmasked");

	// Fresh event drives the line per mask
	chk_irq_rise: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
		s_a_empty_event |=> irq == !mask_q)
		else $error("irq did not follow event");

	// Clearing read drops the line
	chk_read_irq_low: assert property (@(posedge clk_sys) disable iff (!arst_n) // R11
		rd_pend && !drop_valid |=> !irq)
		else $error("irq high after clearing read");

	// Held slot A keeps its fields
	chk_slot_a_held: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
		slot_a_q.valid && !rd_pend |=> $stable(slot_a_q))
		else $error("slot A overwritten");

	// Held slot B keeps its fields
	chk_slot_b_held: assert property (@(posedge clk_sys) disable iff (!arst_n) // R3
		slot_b_q.valid && !rd_pend |=> $stable(slot_b_q))
		else $error("slot B overwritten");

	// Slot B fills only behind slot A
	chk_b_after_a: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
		slot_b_q.valid |-> slot_a_q.valid)
		else $error("slot B valid with slot A empty");

	// No event and no read leaves status alone
	chk_idle_stable: assert property (@(posedge clk_sys) disable iff (!arst_n) // R2
		!drop_valid && !rd_pend |=> $stable(slot_a_q) && $stable(slot_b_q))
		else $error("status changed without cause");

	// Event during a clearing read lands in slot A
	chk_read_event: assert property (@(posedge clk_sys) disable iff (!arst_n) // R12
		s_read_event |=> slot_a_q.valid && !slot_b_q.valid
			&& slot_a_q.reason == $past(drop_reason) && slot_a_q.port == $past(drop_port))
		else $error("event lost in clearing read");

	// Writes to pending change nothing
	chk_pend_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // R10
		acc_go && pwrite && hit_pend && !drop_valid |=> $stable(slot_a_q) && $stable(slot_b_q))
		else $error("pending changed by write");

	// Reserved bits always read zero
	chk_pend_reserved: assert property (@(posedge clk_sys) disable iff (!arst_n) // R4
		pready |-> prdata[31:14] == 18'h0)
		else $error("reserved read bits set");

endmodule
`default_nettype wire

/* File: sdei_defs.svh */
// Register offsets, field positions, reset values and codes for the drop-event interrupt block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SDEI_DEFS_SVH
`define SDEI_DEFS_SVH

// Register indices (printed numbers); byte address is four times the index
`define SDEI_IDX_MASK 16'h1c20
`define SDEI_IDX_PEND 16'h1c21
`define SDEI_ADDR_W 16
// Mask register
`define SDEI_MASK_BIT 0
`define SDEI_MASK_RST 1'h1
// Pending register fields
`define SDEI_A_VALID 0
`define SDEI_A_PORT_LO 1
`define SDEI_A_PORT_HI 2
`define SDEI_A_RSN_LO 3
`define SDEI_A_RSN_HI 6
`define SDEI_B_VALID 7
`define SDEI_B_PORT_LO 8
`define SDEI_B_PORT_HI 9
`define SDEI_B_RSN_LO 10
`define SDEI_B_RSN_HI 13
`define SDEI_PEND_RST 32'h0000_0000
// Drop reason codes
`define SDEI_RSN_BCAST_LVL 4'h0
`define SDEI_RSN_RED 4'h1
`define SDEI_RSN_NO_BUF 4'h2
`define SDEI_RSN_NO_DESC 4'h3
`define SDEI_RSN_NO_DEST 4'h4
`define SDEI_RSN_RX_ERR 4'h5
`define SDEI_RSN_DROP_LVL 4'h6
`define SDEI_RSN_YELLOW 4'h9
// Source port codes
`define SDEI_PORT_0 2'h0
`define SDEI_PORT_1 2'h1
`define SDEI_PORT_2 2'h2

`endif

/* File: sdei_pkg.sv */
// Types shared by the drop-event interrupt block.
// Assumes the constants header sits in the same folder.
`include "sdei_defs.svh"

package sdei_pkg;

	// Drop reason code
	typedef logic [3:0] sdei_reason_t;
	// Ingress port code
	typedef logic [1:0] sdei_port_t;
	// One status slot
	typedef struct packed {
		logic valid;
		sdei_reason_t reason;
		sdei_port_t port;
	} sdei_slot_s;
	// APB access phase tracking
	typedef enum logic [0:0] {
		SDEI_IDLE = 1'b0,
		SDEI_ACC = 1'b1
	} sdei_apb_e;

endpackage

/* File: tb_top.sv */
// Testbench for the drop-event interrupt block: APB register access and drop events.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sdei_defs.svh"

module tb_top;
	import sdei_pkg::*;

	// Byte addresses are four times the register index
	localparam logic [31:0] A_MASK = 32'({`SDEI_IDX_MASK, 2'b00});
	localparam logic [31:0] A_PEND = 32'({`SDEI_IDX_PEND, 2'b00});
	// Every documented drop reason, in order
	localparam logic [3:0] CODES [8] = '{`SDEI_RSN_BCAST_LVL, `SDEI_RSN_RED, `SDEI_RSN_NO_BUF,
		`SDEI_RSN_NO_DESC, `SDEI_RSN_NO_DEST, `SDEI_RSN_RX_ERR, `SDEI_RSN_DROP_LVL, `SDEI_RSN_YELLOW};

	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic drop_valid = 1'b0;
	sdei_reason_t drop_reason = 4'h0;
	sdei_port_t drop_port = 2'h0;
	logic irq;
	// Data and error flag of the last completed transfer
	logic [31:0] rd;
	logic er;
	int n_errors = 0;
	int checks = 0;

	sdei_top sdei_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drop_valid(drop_valid), .drop_reason(drop_reason),
		.drop_port(drop_port), .irq(irq));

	// 100 MHz system clock
	always #5 clk_sys = ~clk_sys;

	// Compares and counts
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Lets the edge settle, then compares the interrupt line
	task automatic chk_irq(input logic e);
		#1;
		chk({31'h0, irq}, {31'h0, e});
	endtask

	// One APB transfer; waits for pready, the watchdog bounds the wait
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle drop event
	task automatic ev(input logic [3:0] r, input logic [1:0] p);
		@(posedge clk_sys);
		drop_valid <= 1'b1;
		drop_reason <= r;
		drop_port <= p;
		@(posedge clk_sys);
		drop_valid <= 1'b0;
	endtask

	// Expected pending word
	function automatic logic [31:0] pend(logic va, logic [3:0] ra, logic [1:0] pa,
		logic vb, logic [3:0] rb, logic [1:0] pb);
		return {18'h0, rb, pb, vb, ra, pa, va};
	endfunction

	// Reset values of both registers and the line
	task automatic t_reset;
		apb(1'b0, A_MASK, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, A_PEND, 32'h0);
		chk(rd, 32'h0);
		chk_irq(1'b0);
	endtask

	// Three events while masked: two recorded, third dropped, no interrupt
	task automatic t_masked;
		ev(`SDEI_RSN_NO_BUF, `SDEI_PORT_2);
		ev(`SDEI_RSN_YELLOW, `SDEI_PORT_1);
		ev(`SDEI_RSN_RED, `SDEI_PORT_0);
		chk_irq(1'b0);
		apb(1'b1, A_PEND, 32'hffff_ffff);
		apb(1'b0, A_PEND, 32'h0);
		chk(rd, pend(1'b1, 4'h2, 2'h2, 1'b1, 4'h9, 2'h1));
		apb(1'b0, A_PEND, 32'h0);
		chk(rd, 32'h0);
	endtask

	// Every reason code through one slot, A and B in turn, unmasked
	task automatic t_codes;
		apb(1'b1, A_MASK, 32'h0);
		for (int i = 0; i < 8; i += 2) begin
			ev(CODES[i], 2'(i % 3));
			chk_irq(1'b1);
			ev(CODES[i + 1], 2'((i + 1) % 3));
			apb(1'b0, A_PEND, 32'h0);
			chk(rd, pend(1'b1, CODES[i], 2'(i % 3), 1'b1, CODES[i + 1], 2'((i + 1) % 3)));
			chk_irq(1'b0);
		end
	endtask

	// Mask set and cleared around one pending event
	task automatic t_toggle;
		apb(1'b1, A_MASK, 32'h1);
		ev(`SDEI_RSN_DROP_LVL, `SDEI_PORT_1);
		chk_irq(1'b0);
		apb(1'b1, A_MASK, 32'h0);
		chk_irq(1'b1);
		apb(1'b0, A_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, A_MASK, 32'hffff_ffff);
		chk_irq(1'b0);
		apb(1'b0, A_MASK, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, A_PEND, 32'h0);
		chk(rd, pend(1'b1, 4'h6, 2'h1, 1'b0, 4'h0, 2'h0));
	endtask

	// Event in the clearing read cycle survives in slot A
	task automatic t_race;
		ev(`SDEI_RSN_NO_DESC, `SDEI_PORT_0);
		fork
			apb(1'b0, A_PEND, 32'h0);
			begin
				@(posedge clk_sys);
				ev(`SDEI_RSN_RX_ERR, `SDEI_PORT_2);
			end
		join
		chk(rd, pend(1'b1, `SDEI_RSN_NO_DESC, `SDEI_PORT_0, 1'b0, 4'h0, 2'h0));
		apb(1'b0, A_PEND, 32'h0);
		chk(rd, pend(1'b1, `SDEI_RSN_RX_ERR, `SDEI_PORT_2, 1'b0, 4'h0, 2'h0));
	endtask

	// Unmapped and misaligned addresses are refused; no low strobe, no mask write
	task automatic t_err;
		apb(1'b0, A_PEND + 32'h8, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, A_MASK + 32'h1, 32'h0);
		chk({31'h0, er}, 32'h1);
		pstrb <= 4'he;
		apb(1'b1, A_MASK, 32'h0);
		pstrb <= 4'hf;
		chk({31'h0, er}, 32'h0);
		apb(1'b0, A_MASK, 32'h0);
		chk(rd, 32'h1);
	endtask

	// Prints the counts and the verdict, then stops
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset;
		t_masked;
		t_codes;
		t_toggle;
		t_race;
		t_err;
		final_report;
	end

	// Watchdog well beyond the roughly 130 cycles the tests need
	initial begin
		#50000;
		n_errors++;
		final_report;
	end
endmodule
`default_nettype wire
